// file: rtl/ompc_pkg.sv
// Package with register map, field positions, states and carriers of the operating-mode power controller.
// Overview of operation
// - Active mode keeps the PLL enabled but bypassed; clocks run at input clock.
// - Active mode lets DMA reach suitably configured L1 memories.
// - In active mode the PLL-off bit disables the PLL control input.
// - Sleep gates the core clock; PLL and system clock keep running.
// - Sleep wakeup samples bypass bit: clear goes full-on, set goes active.
// - DMA accesses to L1 are not serviced in sleep.
// - Deep sleep gates core and system clocks and disables the PLL.
// - Deep sleep blocks asynchronous peripherals from internal resources and external memory.
// - Deep sleep exits only on reset pin, into full-on.
// - Hibernate removes core supply and stops all clocks.
// - Writing zero to the hibernate bit drives regulator wake output low.
// - In hibernate all external pins go high impedance.
// - Any hibernate wakeup, reset pin included, starts full reset then boot.
// - Hibernate wakeup sources are enabled individually; wake output flags the wakeup.
// - Regulator control register survives hibernate; all else is lost.
// - Regulator wake output is active high to request power-up.
// - After a hibernate wakeup, start waits until active-low power good reports core supply ready.
// - Full-on keeps the PLL enabled and not bypassed.
// - Full-on is the default state after power-up.
package ompc_pkg;
    localparam logic [11:0] OMPC_PLL_CONTROL_REGISTER_ADDR  = 12'h000;
    localparam logic [11:0] OMPC_REGULATOR_CONTROL_REGISTER_ADDR   = 12'h004;
    localparam logic [11:0] OMPC_MODE_REQ_ADDR = 12'h008;
    localparam logic [11:0] OMPC_STATUS_ADDR   = 12'h00c;
    localparam logic [11:0] OMPC_WAKE_EN_ADDR  = 12'h010;

    localparam int OMPC_PLL_BYPASS_BIT = 0;
    localparam int OMPC_PLL_OFF_BIT    = 1;
    localparam int OMPC_VR_HIB_BIT     = 0;
    localparam int OMPC_VR_WEN_LSB     = 8;

    localparam int OMPC_WAKE_W = 8;
    localparam int OMPC_SYNC_W = 2;

    localparam logic [1:0]  OMPC_PLL_CONTROL_REGISTER_RST = 2'h0;
    localparam logic [31:0] OMPC_REGULATOR_CONTROL_REGISTER_RST  = 32'h00000001;

    typedef enum logic [2:0] {
        OMPC_REQ_FULL  = 3'h0,
        OMPC_REQ_ACT   = 3'h1,
        OMPC_REQ_SLEEP = 3'h2,
        OMPC_REQ_DEEP  = 3'h3
    } ompc_req_t;

    typedef enum logic [4:0] {
        OMPC_FULL_ON   = 5'b00001,
        OMPC_ACTIVE    = 5'b00010,
        OMPC_SLEEP     = 5'b00100,
        OMPC_DEEP      = 5'b01000,
        OMPC_HIBERNATE = 5'b10000
    } ompc_state_t;

    typedef struct packed {
        logic core_clk_en;
        logic sys_clk_en;
        logic pll_en;
        logic pll_bypass;
        logic pll_control_register_in_en;
        logic dma_l1_en;
        logic async_access_en;
        logic core_power_on;
        logic pins_hiz;
    } ompc_ctl_t;
endpackage : ompc_pkg

// file: rtl/ompc_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module ompc_sync
    import ompc_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    initial begin
        if (WIDTH < 1) $error("ompc_sync width must be at least one");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : ompc_sync

// file: rtl/ompc_decode.sv
// Maps the operating state onto clock gates, PLL controls and access enables.
`timescale 1ns/1ps
module ompc_decode
    import ompc_pkg::*;
(
    input  ompc_state_t state,
    input  wire logic   pll_off,
    output ompc_ctl_t   ctl
);
    always_comb begin
        ctl = '0;
        unique case (state)
            OMPC_FULL_ON: begin
                ctl.core_clk_en     = 1'b1;
                ctl.sys_clk_en      = 1'b1;
                ctl.pll_en          = 1'b1;
                ctl.pll_control_register_in_en   = 1'b1;
                ctl.dma_l1_en       = 1'b1;
                ctl.async_access_en = 1'b1;
                ctl.core_power_on   = 1'b1;
            end
            OMPC_ACTIVE: begin
                ctl.core_clk_en     = 1'b1;
                ctl.sys_clk_en      = 1'b1;
                ctl.pll_en          = 1'b1;
                ctl.pll_bypass      = 1'b1;
                ctl.pll_control_register_in_en   = !pll_off;
                ctl.dma_l1_en       = 1'b1;
                ctl.async_access_en = 1'b1;
                ctl.core_power_on   = 1'b1;
            end
            OMPC_SLEEP: begin
                ctl.sys_clk_en      = 1'b1;
                ctl.pll_en          = 1'b1;
                ctl.pll_control_register_in_en   = 1'b1;
                ctl.async_access_en = 1'b1;
                ctl.core_power_on   = 1'b1;
            end
            OMPC_DEEP: begin
                ctl.core_power_on   = 1'b1;
            end
            OMPC_HIBERNATE: begin
                ctl.pins_hiz        = 1'b1;
            end
            default: begin
                ctl = '0;
            end
        endcase
    end
endmodule : ompc_decode

// file: rtl/ompc_top.sv
// Operating-mode power controller with APB register access.
`timescale 1ns/1ps
module ompc_top
    import ompc_pkg::*;
#(
    parameter int WAKE_W = OMPC_WAKE_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              reset_pin_n,
    input  wire logic [WAKE_W-1:0] wakeup_in,
    input  wire logic              power_good_in_n,
    output logic                   regulator_wake_out,
    output logic                   core_clock_en,
    output logic                   sys_clock_en,
    output logic                   pll_enable,
    output logic                   pll_bypass,
    output logic                   pll_control_register_input_en,
    output logic                   dma_l1_allow,
    output logic                   async_access_allow,
    output logic                   core_power_on,
    output logic                   pins_hiz,
    output logic                   core_reset_n,
    output logic                   boot_start
);
    initial begin
        if (WAKE_W < 1 || WAKE_W > 24) $error("ompc_top wake width out of range");
    end

    ompc_state_t           state;
    ompc_state_t           next_state;
    ompc_ctl_t             ctl;
    logic [1:0]            pll_control_register;
    logic [31:0]           regulator_control_register;
    logic [WAKE_W-1:0]     wakeup_enable_registers;
    logic                  reset_pin_s;
    logic                  power_good_s;
    logic [WAKE_W-1:0]     wakeup_s;
    logic                  hold_start;
    logic                  wr;
    logic                  rd_map;
    logic                  mode_wr;
    ompc_req_t             mode_req;
    logic                  sleep_wake;
    logic                  hib_wake;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
        addr_hit = (a == r);
    endfunction : addr_hit

    ompc_sync #(.WIDTH(WAKE_W + 2), .RESET_VALUE({{WAKE_W{1'b0}}, 2'b11})) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({wakeup_in, reset_pin_n, power_good_in_n}),
        .sync_out ({wakeup_s, reset_pin_s, power_good_s})
    );

    ompc_decode u_decode (
        .state   (state),
        .pll_off (pll_control_register[OMPC_PLL_OFF_BIT]),
        .ctl     (ctl)
    );

    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite;
    assign rd_map  = addr_hit(paddr, OMPC_PLL_CONTROL_REGISTER_ADDR) || addr_hit(paddr, OMPC_REGULATOR_CONTROL_REGISTER_ADDR)
                  || addr_hit(paddr, OMPC_MODE_REQ_ADDR) || addr_hit(paddr, OMPC_STATUS_ADDR)
                  || addr_hit(paddr, OMPC_WAKE_EN_ADDR);
    assign pslverr = psel && penable && !rd_map;
    assign mode_wr = wr && addr_hit(paddr, OMPC_MODE_REQ_ADDR);
    assign mode_req = ompc_req_t'(pwdata[2:0]);

    // Only wakeups that software enabled can end sleep.
    assign sleep_wake = |(wakeup_s & wakeup_enable_registers);
    // Hibernate wakeups are enabled per source in the regulator control register.
    assign hib_wake   = (|(wakeup_s & regulator_control_register[OMPC_VR_WEN_LSB +: WAKE_W]))
                     || !reset_pin_s;

    // The regulator control register sits in the always-on domain, so only presetn clears it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_control_register <= OMPC_REGULATOR_CONTROL_REGISTER_RST;
        end else begin
            if (wr && addr_hit(paddr, OMPC_REGULATOR_CONTROL_REGISTER_ADDR)) begin
                regulator_control_register <= pwdata;
            end
            // A wakeup in the same cycle as a write must not be lost, so the set wins.
            if (state == OMPC_HIBERNATE && hib_wake) begin
                regulator_control_register[OMPC_VR_HIB_BIT] <= 1'b1;
            end
        end
    end

    // Core-domain registers are lost in hibernate and come back at reset values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_control_register    <= OMPC_PLL_CONTROL_REGISTER_RST;
            wakeup_enable_registers <= '0;
        end else if (state == OMPC_HIBERNATE) begin
            pll_control_register    <= OMPC_PLL_CONTROL_REGISTER_RST;
            wakeup_enable_registers <= '0;
        end else if (wr && addr_hit(paddr, OMPC_PLL_CONTROL_REGISTER_ADDR)) begin
            pll_control_register    <= pwdata[1:0];
        end else if (wr && addr_hit(paddr, OMPC_WAKE_EN_ADDR)) begin
            wakeup_enable_registers <= pwdata[WAKE_W-1:0];
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            OMPC_FULL_ON, OMPC_ACTIVE: begin
                if (mode_wr) begin
                    unique case (mode_req)
                        OMPC_REQ_FULL:  next_state = OMPC_FULL_ON;
                        OMPC_REQ_ACT:   next_state = OMPC_ACTIVE;
                        OMPC_REQ_SLEEP: next_state = OMPC_SLEEP;
                        OMPC_REQ_DEEP:  next_state = OMPC_DEEP;
                        default:        next_state = state;
                    endcase
                end
                if (wr && addr_hit(paddr, OMPC_REGULATOR_CONTROL_REGISTER_ADDR) && !pwdata[OMPC_VR_HIB_BIT]) begin
                    next_state = OMPC_HIBERNATE;
                end
            end
            OMPC_SLEEP: begin
                if (sleep_wake) begin
                    next_state = pll_control_register[OMPC_PLL_BYPASS_BIT] ? OMPC_ACTIVE : OMPC_FULL_ON;
                end
            end
            OMPC_DEEP: begin
                if (!reset_pin_s) begin
                    next_state = OMPC_FULL_ON;
                end
            end
            OMPC_HIBERNATE: begin
                if (hib_wake) begin
                    next_state = OMPC_FULL_ON;
                end
            end
            default: begin
                next_state = OMPC_FULL_ON;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= OMPC_FULL_ON;
        end else begin
            state <= next_state;
        end
    end

    // After a hibernate wakeup the core stays in reset until power good is reported.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_start <= 1'b0;
        end else if (state == OMPC_HIBERNATE) begin
            hold_start <= 1'b1;
        end else if (!power_good_s) begin
            hold_start <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_start <= 1'b0;
        end else begin
            boot_start <= hold_start && !power_good_s && state != OMPC_HIBERNATE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            if (addr_hit(paddr, OMPC_PLL_CONTROL_REGISTER_ADDR)) prdata[1:0] <= pll_control_register;
            if (addr_hit(paddr, OMPC_REGULATOR_CONTROL_REGISTER_ADDR)) prdata <= regulator_control_register;
            if (addr_hit(paddr, OMPC_STATUS_ADDR)) prdata[4:0] <= state;
            if (addr_hit(paddr, OMPC_WAKE_EN_ADDR)) prdata[WAKE_W-1:0] <= wakeup_enable_registers;
        end
    end

    // Wake output follows the hibernate bit: low asks the regulator to shut down.
    assign regulator_wake_out = regulator_control_register[OMPC_VR_HIB_BIT];

    assign core_clock_en      = ctl.core_clk_en && !hold_start;
    assign sys_clock_en       = ctl.sys_clk_en && !hold_start;
    assign pll_enable         = ctl.pll_en;
    assign pll_bypass         = ctl.pll_bypass;
    assign pll_control_register_input_en   = ctl.pll_control_register_in_en;
    assign dma_l1_allow       = ctl.dma_l1_en && !hold_start;
    assign async_access_allow = ctl.async_access_en;
    assign core_power_on      = ctl.core_power_on;
    assign pins_hiz           = ctl.pins_hiz;
    assign core_reset_n       = !hold_start;

    chk_sleep_wake_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        state == OMPC_SLEEP && sleep_wake |=> state == (pll_control_register[OMPC_PLL_BYPASS_BIT]
        ? OMPC_ACTIVE : OMPC_FULL_ON)) else $error("sleep wake went to wrong state");
    chk_deep_exit: assert property (@(posedge pclk) disable iff (!presetn)
        state == OMPC_DEEP && reset_pin_s |=> state == OMPC_DEEP) else $error("deep sleep left without reset");
    chk_deep_reset_full: assert property (@(posedge pclk) disable iff (!presetn)
        state == OMPC_DEEP && !reset_pin_s |=> state == OMPC_FULL_ON) else $error("deep sleep reset not full-on");
    chk_active_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        state == OMPC_ACTIVE |-> pll_bypass && pll_enable && core_clock_en == !hold_start)
        else $error("active mode clocks wrong");
    chk_sleep_gates: assert property (@(posedge pclk) disable iff (!presetn)
        state == OMPC_SLEEP |-> !core_clock_en && pll_enable && !dma_l1_allow)
        else $error("sleep gating wrong");
    chk_deep_gates: assert property (@(posedge pclk) disable iff (!presetn)
        state == OMPC_DEEP |-> !core_clock_en && !sys_clock_en && !pll_enable && !async_access_allow)
        else $error("deep sleep gating wrong");
    chk_hib_entry: assert property (@(posedge pclk) disable iff (!presetn)
        wr && addr_hit(paddr, OMPC_REGULATOR_CONTROL_REGISTER_ADDR) && !pwdata[OMPC_VR_HIB_BIT]
        && !(state == OMPC_HIBERNATE && hib_wake)
        |=> !regulator_wake_out) else $error("wake output not low after hibernate write");
    chk_hib_pins: assert property (@(posedge pclk) disable iff (!presetn)
        state == OMPC_HIBERNATE |-> pins_hiz && !core_power_on && !sys_clock_en)
        else $error("hibernate outputs wrong");
    chk_pg_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(state == OMPC_HIBERNATE) && power_good_s |-> !core_reset_n && !core_clock_en)
        else $error("started before power good");
    chk_pll_off: assert property (@(posedge pclk) disable iff (!presetn)
        state == OMPC_ACTIVE && pll_control_register[OMPC_PLL_OFF_BIT] |-> !pll_control_register_input_en)
        else $error("pll control input not disabled");
endmodule : ompc_top

// file: verif/ompc_regulator_model.sv
// Behavioural model of the external regulator that powers the core supply.
`timescale 1ns/1ps
module ompc_regulator_model #(
    parameter int RAMP = 12
) (
    input  wire logic pclk,
    input  wire logic wake_high,
    output logic      power_good_n
);
    int ramp_cnt = 0;

    initial begin
        power_good_n = 1'b1;
    end

    // The wake line is high-true, so it drives the low-true shutdown input directly.
    // Good power is reported only after a ramp, so a slow supply is always modelled.
    always @(posedge pclk) begin
        if (wake_high !== 1'b1) begin
            ramp_cnt     <= 0;
            power_good_n <= 1'b1;
        end else if (ramp_cnt < RAMP) begin
            ramp_cnt     <= ramp_cnt + 1;
            power_good_n <= 1'b1;
        end else begin
            power_good_n <= 1'b0;
        end
    end
endmodule : ompc_regulator_model

// file: verif/operating_mode_power_controller_bench.sv
// Self-checking bench for the operating-mode power controller.
`timescale 1ns/1ps
module operating_mode_power_controller_bench;
    import ompc_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready, pslverr, regulator_wake_out, power_good_in_n;
    logic        reset_pin_n = 1'b1;
    logic [7:0]  wakeup_in = 8'h00;
    logic        core_clock_en, sys_clock_en, pll_enable, pll_bypass, pll_control_register_input_en;
    logic        dma_l1_allow, async_access_allow, core_power_on, pins_hiz, core_reset_n, boot_start;
    int          num_errors = 0;
    int          total_checks = 0;
    logic [31:0] rd;
    logic        err;

    always #5 pclk = ~pclk;

    ompc_top #(.WAKE_W(8)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .reset_pin_n, .wakeup_in, .power_good_in_n, .regulator_wake_out, .core_clock_en,
        .sys_clock_en, .pll_enable, .pll_bypass, .pll_control_register_input_en, .dma_l1_allow,
        .async_access_allow, .core_power_on, .pins_hiz, .core_reset_n, .boot_start
    );

    ompc_regulator_model #(.RAMP(12)) u_reg (
        .pclk         (pclk),
        .wake_high    (regulator_wake_out),
        .power_good_n (power_good_in_n)
    );

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge pclk);
        #1;
    endtask : tick

    // The request is held until pready is seen high; the short settle lets outputs land.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wait_status(input logic [4:0] exp, input string msg);
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, OMPC_STATUS_ADDR, 32'h00000000);
            if (rd[4:0] === exp) break;
        end
        check({27'h0, rd[4:0]}, {27'h0, exp}, msg);
    endtask : wait_status

    // Order is core clock, system clock, PLL enable, PLL bypass.
    task automatic ctl(input logic [3:0] exp, input logic [3:0] mask, input string msg);
        check({28'h0, {core_clock_en, sys_clock_en, pll_enable, pll_bypass} & mask}, {28'h0, exp & mask}, msg);
    endtask : ctl

    task automatic t_reset();
        wait_status(OMPC_FULL_ON, "reset state");
        ctl(4'b1110, 4'hf, "full-on clocks");
        check({31'h0, regulator_wake_out}, 32'h1, "wake out after reset");
        apb(1'b0, OMPC_REGULATOR_CONTROL_REGISTER_ADDR, 32'h0);
        check(rd, OMPC_REGULATOR_CONTROL_REGISTER_RST, "regulator_control_register reset");
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
    endtask : t_reset

    task automatic t_active();
        apb(1'b1, OMPC_MODE_REQ_ADDR, 32'h1);
        wait_status(OMPC_ACTIVE, "active entered");
        ctl(4'b1111, 4'hf, "active clocks");
        check({31'h0, dma_l1_allow}, 32'h1, "active dma");
        apb(1'b1, OMPC_PLL_CONTROL_REGISTER_ADDR, 32'h3);
        check({31'h0, pll_control_register_input_en}, 32'h0, "pll input off");
        apb(1'b1, OMPC_PLL_CONTROL_REGISTER_ADDR, 32'h1);
        check({31'h0, pll_control_register_input_en}, 32'h1, "pll input back");
    endtask : t_active

    task automatic t_sleep();
        apb(1'b1, OMPC_WAKE_EN_ADDR, 32'h1);
        for (int b = 1; b >= 0; b--) begin
            apb(1'b1, OMPC_PLL_CONTROL_REGISTER_ADDR, 32'(b));
            apb(1'b1, OMPC_MODE_REQ_ADDR, 32'h2);
            wait_status(OMPC_SLEEP, "sleep entered");
            ctl(4'b0110, 4'b1110, "sleep clocks");
            check({31'h0, dma_l1_allow}, 32'h0, "sleep dma");
            @(posedge pclk);
            wakeup_in <= 8'h02;
            repeat (8) @(posedge pclk);
            wait_status(OMPC_SLEEP, "disabled source ignored");
            @(posedge pclk);
            wakeup_in <= 8'h01;
            wait_status((b == 1) ? OMPC_ACTIVE : OMPC_FULL_ON, "sleep wake target");
            @(posedge pclk);
            wakeup_in <= 8'h00;
        end
    endtask : t_sleep

    task automatic t_deep();
        apb(1'b1, OMPC_MODE_REQ_ADDR, 32'h3);
        wait_status(OMPC_DEEP, "deep entered");
        ctl(4'b0000, 4'b1110, "deep clocks");
        check({31'h0, async_access_allow}, 32'h0, "async blocked");
        @(posedge pclk);
        wakeup_in <= 8'h01;
        repeat (8) @(posedge pclk);
        wakeup_in <= 8'h00;
        apb(1'b1, OMPC_MODE_REQ_ADDR, 32'h1);
        wait_status(OMPC_DEEP, "deep kept");
        @(posedge pclk);
        reset_pin_n <= 1'b0;
        repeat (4) @(posedge pclk);
        reset_pin_n <= 1'b1;
        wait_status(OMPC_FULL_ON, "deep exit");
    endtask : t_deep

    // First pass wakes on an enabled source, second on the reset pin.
    task automatic t_hib();
        int n;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OMPC_PLL_CONTROL_REGISTER_ADDR, 32'h1);
            apb(1'b0, OMPC_PLL_CONTROL_REGISTER_ADDR, 32'h0);
            check(rd, 32'h1, "state saved before hibernate");
            apb(1'b1, OMPC_REGULATOR_CONTROL_REGISTER_ADDR, 32'h100);
            check({31'h0, regulator_wake_out}, 32'h0, "wake out low");
            wait_status(OMPC_HIBERNATE, "hibernate entered");
            ctl(4'b0000, 4'b1110, "hibernate clocks");
            check({30'h0, core_power_on, pins_hiz}, 32'h1, "supply off, pins hiz");
            @(posedge pclk);
            if (k == 0) begin
                wakeup_in <= 8'h01;
            end else begin
                reset_pin_n <= 1'b0;
            end
            for (n = 0; n < 20 && regulator_wake_out !== 1'b1; n++) tick();
            check({31'h0, regulator_wake_out}, 32'h1, "wake out high");
            @(posedge pclk);
            wakeup_in   <= 8'h00;
            reset_pin_n <= 1'b1;
            for (n = 0; n < 40 && boot_start !== 1'b1; n++) begin
                if (power_good_in_n === 1'b1) begin
                    check({31'h0, core_reset_n}, 32'h0, "held in reset");
                end
                tick();
            end
            check({30'h0, power_good_in_n, boot_start}, 32'h1, "boot after power good");
            tick();
            check({31'h0, boot_start}, 32'h0, "boot pulse");
            apb(1'b0, OMPC_REGULATOR_CONTROL_REGISTER_ADDR, 32'h0);
            check(rd, 32'h101, "regulator_control_register kept");
            apb(1'b0, OMPC_PLL_CONTROL_REGISTER_ADDR, 32'h0);
            check(rd, 32'h0, "pll_control_register lost");
        end
    endtask : t_hib

    initial begin
        #50000;
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (15) @(posedge pclk);
        t_reset();
        t_active();
        t_sleep();
        t_deep();
        t_hib();
        wrap_up();
    end
endmodule : operating_mode_power_controller_bench
